// ==== srs_defs.svh ====
// Timing counts, reset values and source positions of the reset sequencer
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH

// ****************************************
// Clock
// ****************************************
`define SRS_CLK_PERIOD_NS 100

// ****************************************
// Timing
// ****************************************
`define SRS_POR_DLY_MS 10
`define SRS_POR_DLY_CYC ((`SRS_POR_DLY_MS * 1000000) / `SRS_CLK_PERIOD_NS)
`define SRS_RST_DLY_US 50
`define SRS_RST_DLY_CYC ((`SRS_RST_DLY_US * 1000) / `SRS_CLK_PERIOD_NS)
`define SRS_PIN_LOW_US 15
`define SRS_PIN_LOW_CYC (((`SRS_PIN_LOW_US * 1000) + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_MCD_RESP_NS 625000
`define SRS_MCD_RESP_CYC (`SRS_MCD_RESP_NS / `SRS_CLK_PERIOD_NS)
`define SRS_IDLE_WAKE_CYC 2

// ****************************************
// Reset values
// ****************************************
`define SRS_RESET_VECTOR 16'h0000
`define SRS_PORT_LATCH_RST 1'b1
`define SRS_PORT_OD_RST 1'b1
`define SRS_PORT_PULLUP_RST 1'b1
`define SRS_WDT_EN_RST 1'b1
`define SRS_RETAIN_RST 1'b0

// ****************************************
// Reset source positions
// ****************************************
`define SRS_SRC_POR 0
`define SRS_SRC_PIN 1
`define SRS_SRC_CMP 2
`define SRS_SRC_SW 3
`define SRS_SRC_SUP 4
`define SRS_SRC_WDT 5
`define SRS_SRC_MCD 6
`define SRS_SRC_FLASH 7
`define SRS_SRC_NUM 8

`endif

// ==== srs_pkg.sv ====
// Types shared by the reset sequencer modules
package srs_pkg;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		ST_POR_HOLD,
		ST_SRC_HOLD,
		ST_RELEASE,
		ST_RUN,
		ST_IDLE,
		ST_WAKE
	} srs_state_t;

	// ****************************************
	// System clock selection
	// ****************************************
	typedef enum logic [1:0] {
		CLK_INT,
		CLK_HF,
		CLK_LF,
		CLK_EXT
	} srs_clk_t;

endpackage

// ==== srs_if.sv ====
// Interfaces between the sequencer and its memory and clock detector
`timescale 1ns/1ps

interface srs_ram_if #(parameter int AW = 4, parameter int DW = 8);
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface

interface srs_mcd_if;
	logic arm;
	logic edge_seen;
	logic fail;
	modport ctl (output arm, output edge_seen, input fail);
	modport det (input arm, input edge_seen, output fail);
endinterface

// ==== srs_ram.sv ====
// Data memory whose contents survive every reset
`timescale 1ns/1ps

module srs_ram #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Memory access
	srs_ram_if.mem bus
);
	logic [DW-1:0] mem_q [0:(1<<AW)-1];
	logic [DW-1:0] rdata_ff;

	// ****************************************
	// Array without reset
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (clk_en && bus.we) begin
			mem_q[bus.addr] <= bus.wdata;
		end
	end

	// ****************************************
	// Read register
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= '0;
		end else if (clk_en) begin
			rdata_ff <= mem_q[bus.addr];
		end
	end

	assign bus.rdata = rdata_ff;

endmodule

// ==== srs_mcd.sv ====
// Missing clock detector
`timescale 1ns/1ps
`include "srs_defs.svh"

module srs_mcd #(
	parameter int RESP_CYC = `SRS_MCD_RESP_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Detector link
	srs_mcd_if.det mcd
);
	logic [15:0] gap_cnt_ff;
	logic [15:0] nxt_gap_cnt;
	logic fail_ff;
	logic nxt_fail;
	wire logic at_limit;

	// ****************************************
	// Gap counter
	// ****************************************
	assign at_limit = (gap_cnt_ff == 16'(RESP_CYC - 1));
	assign nxt_gap_cnt = (!mcd.arm || mcd.edge_seen) ? 16'h0000 :
		(at_limit ? gap_cnt_ff : gap_cnt_ff + 16'h0001);
	assign nxt_fail = mcd.arm && !mcd.edge_seen && at_limit;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gap_cnt_ff <= 16'h0000;
			fail_ff <= 1'b0;
		end else if (clk_en) begin
			gap_cnt_ff <= nxt_gap_cnt;
			fail_ff <= nxt_fail;
		end
	end

	assign mcd.fail = fail_ff;

	a_mcd_fire_time: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		(mcd.arm && !mcd.edge_seen && at_limit) |=> mcd.fail)
		else $error("clock loss not flagged at limit");

endmodule

// ==== srs_top.sv ====
// Reset sequencer: source gathering, hold timing and reset-time state control
`timescale 1ns/1ps
`include "srs_defs.svh"

// Functional notes
// - Any reset halts the core for the whole reset state.
// - Peripheral registers reset; power-on-only bits change only on power-on.
// - Port pins forced to a defined state in reset unless retained.
// - Entering reset disables all interrupts and timers.
// - Reset never touches RAM contents.
// - Port latches default to 1, open-drain, weak pull-ups on.
// - Retention keeps port, converter and reference state except on power-on.
// - Power-on and supply-monitor resets drive the reset pin low; supply resets drive it only when reset_cause records the supply monitor.
// - Leaving reset clears the program counter to address 0x0000.
// - Leaving reset selects the internal oscillator as system clock.
// - Leaving reset enables the watchdog.
// - Eight reset sources are accepted.
// - Power-on reset is held about 10 ms after supply rises.
// - Non-power-on resets release execution about 50 us after source release.
// - Reset pin low for at least 15 us causes a reset.
// - Missing-clock detector flags a system clock that stops or slows.
// - Missing-clock reset follows the last clock edge within bounded time.
// - Idle mode resumes within 2 to 3 cycles after wake-up.
module srs_top
	import srs_pkg::*;
#(
	parameter int PW = 8,
	parameter int AW = 4,
	parameter int POR_CYC = `SRS_POR_DLY_CYC,
	parameter int RST_CYC = `SRS_RST_DLY_CYC,
	parameter int MCD_CYC = `SRS_MCD_RESP_CYC
) (
	// Clock, power-on reset and enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Reset sources
	input wire logic external_reset_pin_n_in,
	input wire logic supply_mon_req,
	input wire logic cmp_reset_req,
	input wire logic sw_reset_req,
	input wire logic wdt_reset_req,
	input wire logic flash_err_req,
	input wire logic system_clock_edge,
	// Reset pin drive
	output logic external_reset_pin_n_out,
	output logic external_reset_pin_n_oe_n,
	// Core control
	output logic core_halt,
	output logic periph_reset,
	output logic por_reset,
	output logic irq_disable,
	output logic timer_disable,
	input wire logic core_fetch,
	input wire logic idle_req,
	input wire logic wake_evt,
	output logic [15:0] program_counter,
	output logic [`SRS_SRC_NUM-1:0] reset_cause,
	// Clock and watchdog
	input wire logic clk_sel_wr,
	input wire srs_clk_t clk_sel_wdata,
	output srs_clk_t system_clock_sel,
	input wire logic wdt_disable,
	output logic wdt_enable,
	// Port state and retention
	input wire logic retain_wr,
	input wire logic retain_wdata,
	input wire logic port_cfg_wr,
	input wire logic [PW-1:0] port_latch_wdata,
	input wire logic [PW-1:0] port_od_wdata,
	input wire logic [PW-1:0] port_pullup_wdata,
	output logic [PW-1:0] port_latch,
	output logic [PW-1:0] port_od_mode,
	output logic [PW-1:0] port_pullup_en,
	output logic conv_retain,
	output logic vref_retain,
	// Data memory
	input wire logic ram_we,
	input wire logic [AW-1:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	output logic [7:0] ram_rdata
);

	localparam int CW = 24;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [`SRS_SRC_NUM-1:0] srs_pick(input logic [`SRS_SRC_NUM-1:0] v);
		srs_pick = v & (~v + 8'h01);
	endfunction

	function automatic logic srs_cnt_done(input logic [CW-1:0] cnt, input int lim);
		srs_cnt_done = (cnt >= CW'(lim - 1));
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	srs_state_t state_ff;
	srs_state_t nxt_state;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic pin_s1_ff;
	logic pin_s2_ff;
	logic sup_s1_ff;
	logic sup_s2_ff;
	logic [7:0] pin_low_ff;
	logic [7:0] nxt_pin_low;
	logic [`SRS_SRC_NUM-1:0] cause_ff;
	logic [`SRS_SRC_NUM-1:0] nxt_cause;
	logic [15:0] pc_ff;
	logic [15:0] nxt_pc;
	srs_clk_t clk_sel_ff;
	srs_clk_t nxt_clk_sel;
	logic wdt_en_ff;
	logic nxt_wdt_en;
	logic retain_ff;
	logic nxt_retain;
	logic [PW-1:0] latch_ff;
	logic [PW-1:0] nxt_latch;
	logic [PW-1:0] od_ff;
	logic [PW-1:0] nxt_od;
	logic [PW-1:0] pullup_ff;
	logic [PW-1:0] nxt_pullup;
	logic pin_oe_n_ff;
	logic nxt_pin_oe_n;
	wire logic in_reset;
	wire logic running;
	wire logic pin_driving;
	wire logic pin_req;
	wire logic [`SRS_SRC_NUM-1:0] src_vec;
	wire logic src_any;
	wire logic hold_done;
	wire logic port_force;

	srs_ram_if #(.AW(AW), .DW(8)) ram_bus ();
	srs_mcd_if mcd_bus ();

	// ****************************************
	// Source synchronisers
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
			sup_s1_ff <= 1'b0;
			sup_s2_ff <= 1'b0;
		end else if (clk_en) begin
			pin_s1_ff <= external_reset_pin_n_in;
			pin_s2_ff <= pin_s1_ff;
			sup_s1_ff <= supply_mon_req;
			sup_s2_ff <= sup_s1_ff;
		end
	end

	// ****************************************
	// Reset pin low-time filter
	// ****************************************
	assign pin_req = (pin_low_ff == 8'(`SRS_PIN_LOW_CYC));
	assign nxt_pin_low = (pin_s2_ff || pin_driving) ? 8'h00 :
		(pin_req ? pin_low_ff : pin_low_ff + 8'h01);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_low_ff <= 8'h00;
		end else if (clk_en) begin
			pin_low_ff <= nxt_pin_low;
		end
	end

	// ****************************************
	// Source gathering
	// ****************************************
	assign src_vec[`SRS_SRC_POR] = 1'b0;
	assign src_vec[`SRS_SRC_PIN] = pin_req;
	assign src_vec[`SRS_SRC_CMP] = cmp_reset_req;
	assign src_vec[`SRS_SRC_SW] = sw_reset_req;
	assign src_vec[`SRS_SRC_SUP] = sup_s2_ff;
	assign src_vec[`SRS_SRC_WDT] = wdt_reset_req;
	assign src_vec[`SRS_SRC_MCD] = mcd_bus.fail;
	assign src_vec[`SRS_SRC_FLASH] = flash_err_req;
	assign src_any = |src_vec;

	// ****************************************
	// Missing clock detector
	// ****************************************
	assign mcd_bus.arm = (state_ff != ST_POR_HOLD);
	assign mcd_bus.edge_seen = system_clock_edge;

	srs_mcd #(.RESP_CYC(MCD_CYC)) u_mcd (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.mcd(mcd_bus.det)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	assign hold_done = (state_ff == ST_POR_HOLD) ? srs_cnt_done(cnt_ff, POR_CYC) :
		(state_ff == ST_RELEASE) ? srs_cnt_done(cnt_ff, RST_CYC) :
		srs_cnt_done(cnt_ff, `SRS_IDLE_WAKE_CYC - 1);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff + 24'h000001;
		unique case (state_ff)
			ST_POR_HOLD: begin
				if (sup_s2_ff) begin
					nxt_cnt = '0;
				end else if (hold_done) begin
					nxt_state = ST_RUN;
				end
			end
			ST_SRC_HOLD: begin
				nxt_cnt = '0;
				if (!src_any) begin
					nxt_state = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				if (src_any) begin
					nxt_state = ST_SRC_HOLD;
				end else if (hold_done) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				nxt_cnt = '0;
				if (src_any) begin
					nxt_state = ST_SRC_HOLD;
				end else if (idle_req) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				nxt_cnt = '0;
				if (src_any) begin
					nxt_state = ST_SRC_HOLD;
				end else if (wake_evt) begin
					nxt_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (src_any) begin
					nxt_state = ST_SRC_HOLD;
				end else if (hold_done) begin
					nxt_state = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_POR_HOLD;
			cnt_ff <= '0;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// ****************************************
	// Reset state decode
	// ****************************************
	assign in_reset = (state_ff == ST_POR_HOLD) || (state_ff == ST_SRC_HOLD) ||
		(state_ff == ST_RELEASE);
	assign running = (state_ff == ST_RUN);
	assign core_halt = !running;
	assign periph_reset = in_reset;
	assign por_reset = (state_ff == ST_POR_HOLD);
	assign irq_disable = in_reset;
	assign timer_disable = in_reset;

	// ****************************************
	// Reset cause
	// ****************************************
	assign nxt_cause = (src_any && (state_ff != ST_SRC_HOLD) && (state_ff != ST_POR_HOLD)) ?
		srs_pick(src_vec) : cause_ff;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cause_ff <= 8'h01;
		end else if (clk_en) begin
			cause_ff <= nxt_cause;
		end
	end

	assign reset_cause = cause_ff;

	// ****************************************
	// Reset pin drive
	// ****************************************
	assign pin_driving = !pin_oe_n_ff;
	assign nxt_pin_oe_n = !((nxt_state == ST_POR_HOLD) ||
		((nxt_state == ST_SRC_HOLD || nxt_state == ST_RELEASE) &&
		nxt_cause[`SRS_SRC_SUP]));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_oe_n_ff <= 1'b0;
		end else if (clk_en) begin
			pin_oe_n_ff <= nxt_pin_oe_n;
		end
	end

	assign external_reset_pin_n_out = 1'b0;
	assign external_reset_pin_n_oe_n = pin_oe_n_ff;

	// ****************************************
	// Program counter, clock select, watchdog
	// ****************************************
	assign nxt_pc = in_reset ? `SRS_RESET_VECTOR :
		((running && core_fetch) ? pc_ff + 16'h0001 : pc_ff);
	assign nxt_clk_sel = in_reset ? CLK_INT :
		((running && clk_sel_wr) ? clk_sel_wdata : clk_sel_ff);
	assign nxt_wdt_en = in_reset ? `SRS_WDT_EN_RST :
		((running && wdt_disable) ? 1'b0 : wdt_en_ff);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pc_ff <= `SRS_RESET_VECTOR;
			clk_sel_ff <= CLK_INT;
			wdt_en_ff <= `SRS_WDT_EN_RST;
		end else if (clk_en) begin
			pc_ff <= nxt_pc;
			clk_sel_ff <= nxt_clk_sel;
			wdt_en_ff <= nxt_wdt_en;
		end
	end

	assign program_counter = pc_ff;
	assign system_clock_sel = clk_sel_ff;
	assign wdt_enable = wdt_en_ff;

	// ****************************************
	// Port state and retention
	// ****************************************
	assign nxt_retain = (running && retain_wr) ? retain_wdata : retain_ff;
	assign port_force = (in_reset || src_any) && !retain_ff;
	assign nxt_latch = port_force ? {PW{`SRS_PORT_LATCH_RST}} :
		((running && port_cfg_wr) ? port_latch_wdata : latch_ff);
	assign nxt_od = port_force ? {PW{`SRS_PORT_OD_RST}} :
		((running && port_cfg_wr) ? port_od_wdata : od_ff);
	assign nxt_pullup = port_force ? {PW{`SRS_PORT_PULLUP_RST}} :
		((running && port_cfg_wr) ? port_pullup_wdata : pullup_ff);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			retain_ff <= `SRS_RETAIN_RST;
			latch_ff <= {PW{`SRS_PORT_LATCH_RST}};
			od_ff <= {PW{`SRS_PORT_OD_RST}};
			pullup_ff <= {PW{`SRS_PORT_PULLUP_RST}};
		end else if (clk_en) begin
			retain_ff <= nxt_retain;
			latch_ff <= nxt_latch;
			od_ff <= nxt_od;
			pullup_ff <= nxt_pullup;
		end
	end

	assign port_latch = latch_ff;
	assign port_od_mode = od_ff;
	assign port_pullup_en = pullup_ff;
	assign conv_retain = retain_ff && !por_reset;
	assign vref_retain = retain_ff && !por_reset;

	// ****************************************
	// Data memory
	// ****************************************
	assign ram_bus.we = ram_we && running;
	assign ram_bus.addr = ram_addr;
	assign ram_bus.wdata = ram_wdata;
	assign ram_rdata = ram_bus.rdata;

	srs_ram #(.AW(AW), .DW(8)) u_ram (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.bus(ram_bus.mem)
	);

	// ****************************************
	// Checks
	// ****************************************
	a_src_halts_core: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		(running && src_any) |=> core_halt && periph_reset)
		else $error("reset source did not halt core");

	a_ports_default_set: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		(in_reset && !retain_ff) |=> (port_latch == {PW{1'b1}}) && (port_od_mode == {PW{1'b1}}))
		else $error("port latches not at default in reset");

	a_ports_kept_retain: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		(state_ff == ST_SRC_HOLD && retain_ff) |=> $stable(port_latch))
		else $error("retained port state changed");

	a_pin_drive_sup: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		(in_reset && cause_ff[`SRS_SRC_SUP]) |-> !external_reset_pin_n_oe_n)
		else $error("reset pin not driven in supply reset");

	a_exit_state_clean: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		($rose(running) && $past(in_reset)) |-> (program_counter == 16'h0000) &&
		(system_clock_sel == CLK_INT) && wdt_enable)
		else $error("state not clean on reset exit");

	a_irq_timer_off: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		(running && src_any) |=> irq_disable && timer_disable)
		else $error("interrupts or timers left on in reset");

	a_wake_latency: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		(state_ff == ST_IDLE && wake_evt && !src_any) |-> ##[2:3] running)
		else $error("idle wake-up too slow");

	a_release_delay: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		(state_ff == ST_RELEASE && running == 1'b0 && !src_any && nxt_state == ST_RUN) |->
		(cnt_ff == CW'(RST_CYC - 1)))
		else $error("release delay wrong");

	a_pin_filter_len: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
		pin_req |-> (pin_low_ff == 8'(`SRS_PIN_LOW_CYC)))
		else $error("pin request before minimum low time");

endmodule

// ==== srs_pin_model.sv ====
// Far-side model of the reset pin with its external pull-up
`timescale 1ns/1ps

module srs_pin_model (
	// Clock
	input wire logic ref_clk,
	// Pin drive from the device
	input wire logic pin_out,
	input wire logic pin_oe_n,
	// Resolved pin level
	output logic pin_n
);
	logic ext_low = 1'b0;

	// ****************************************
	// Wire level
	// ****************************************
	// Pull-up unless the device or the agent pulls low
	assign pin_n = (ext_low || (!pin_oe_n && !pin_out)) ? 1'b0 : 1'b1;

	// ****************************************
	// External agent
	// ****************************************
	// Hold the pin low for n cycles
	task automatic pull_low(input int n);
		ext_low <= 1'b1;
		repeat (n) @(posedge ref_clk);
		#1;
		ext_low <= 1'b0;
	endtask
endmodule

// ==== tb_top.sv ====
// Self-checking testbench of the reset sequencer
`timescale 1ns/1ps

module tb_top;
	import srs_pkg::*;
	localparam int POR = 20;
	localparam int RST = 5;
	localparam int MCD = 16;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] src = '0;
	logic pin_n, pin_out, pin_oe_n, halt, prst, porr, irqd, tmd, wen, cret, vret;
	logic sce = 1'b0, edge_on = 1'b1, fetch = 1'b0, idle = 1'b0, wake = 1'b0, ce = 1'b1;
	logic csw = 1'b0, wdis = 1'b0, rwr = 1'b0, rdat = 1'b0, pwr = 1'b0, rwe = 1'b0;
	srs_clk_t csd = CLK_INT;
	srs_clk_t csel;
	logic [7:0] pl = '0, po = '0, pp = '0, rwd = '0, lat, odm, pue, rrd, cause;
	logic [3:0] ra = '0;
	logic [15:0] pc;
	int error_cnt = 0;
	int comparisons = 0;
	int n;
	int exp_ram[int];
	int cbit[5] = '{2, 3, 4, 5, 7};

	// ****************************************
	// Design and far side
	// ****************************************
	srs_top #(.POR_CYC(POR), .RST_CYC(RST), .MCD_CYC(MCD)) uut (
		.ref_clk(ref_clk), .rst(rst), .clk_en(ce),
		.external_reset_pin_n_in(pin_n), .supply_mon_req(src[2]), .cmp_reset_req(src[0]),
		.sw_reset_req(src[1]), .wdt_reset_req(src[3]), .flash_err_req(src[4]),
		.system_clock_edge(sce), .external_reset_pin_n_out(pin_out),
		.external_reset_pin_n_oe_n(pin_oe_n), .core_halt(halt), .periph_reset(prst),
		.por_reset(porr), .irq_disable(irqd), .timer_disable(tmd), .core_fetch(fetch),
		.idle_req(idle), .wake_evt(wake), .program_counter(pc), .reset_cause(cause),
		.clk_sel_wr(csw), .clk_sel_wdata(csd), .system_clock_sel(csel),
		.wdt_disable(wdis), .wdt_enable(wen), .retain_wr(rwr), .retain_wdata(rdat),
		.port_cfg_wr(pwr), .port_latch_wdata(pl), .port_od_wdata(po),
		.port_pullup_wdata(pp), .port_latch(lat), .port_od_mode(odm),
		.port_pullup_en(pue), .conv_retain(cret), .vref_retain(vret),
		.ram_we(rwe), .ram_addr(ra), .ram_wdata(rwd), .ram_rdata(rrd)
	);
	srs_pin_model pin (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_n(pin_n));

	initial forever begin
		#50 ref_clk = ~ref_clk;
	end

	// System clock edges, one pulse every five cycles
	initial forever begin
		repeat (4) @(posedge ref_clk);
		#1;
		sce <= edge_on;
		@(posedge ref_clk);
		#1;
		sce <= 1'b0;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	// Count cycles until core_halt reaches v
	task automatic wait_halt(input logic v, input int lim);
		n = 0;
		while (halt !== v && n < lim) begin
			tick(1);
			n++;
		end
		chk("halt", 16'(halt), 16'(v));
	endtask

	task automatic win(input string nm, input int lo, input int hi);
		chk(nm, 16'(n >= lo && n <= hi), 16'h0001);
	endtask

	task automatic ports(input logic [7:0] l, input logic [7:0] o, input logic [7:0] p);
		chk("latch", 16'(lat), 16'(l));
		chk("od_mode", 16'(odm), 16'(o));
		chk("pullup", 16'(pue), 16'(p));
	endtask

	task automatic run_dflt();
		chk("pc", pc, 16'h0000);
		chk("clk_sel", 16'(csel), 16'(CLK_INT));
		chk("wdt_en", 16'(wen), 16'h0001);
	endtask

	task automatic cfg_ports();
		pl = 8'($urandom);
		po = 8'($urandom);
		pp = 8'($urandom);
		pwr = 1'b1;
		tick(1);
		pwr = 1'b0;
	endtask

	task automatic ram_chk();
		foreach (exp_ram[a]) begin
			ra = 4'(a);
			tick(1);
			chk("ram", 16'(rrd), 16'(exp_ram[a]));
		end
	endtask

	task automatic por();
		rst = 1'b1;
		tick(4);
		chk("oe_n_por", 16'(pin_oe_n), 16'h0000);
		chk("pin_lvl", 16'(pin_n), 16'h0000);
		chk("halt_por", 16'(halt), 16'h0001);
		chk("por_flag", 16'(porr), 16'h0001);
		chk("cause_por", 16'(cause), 16'h0001);
		chk("conv_ret", 16'(cret), 16'h0000);
		ports(8'hff, 8'hff, 8'hff);
		run_dflt();
		rst = 1'b0;
		wait_halt(1'b0, POR + 10);
		win("por_hold", POR, POR + 4);
		chk("oe_n_run", 16'(pin_oe_n), 16'h0001);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(32'hfe6e));
		por();
		rwe = 1'b1;
		repeat (4) begin
			ra = 4'($urandom);
			rwd = 8'($urandom);
			exp_ram[int'(ra)] = int'(rwd);
			tick(1);
		end
		rwe = 1'b0;
		// Comparator, software, supply, watchdog and flash sources in turn
		for (int i = 0; i < 5; i++) begin
			cfg_ports();
			csd = CLK_HF;
			csw = 1'b1;
			wdis = 1'b1;
			fetch = 1'b1;
			tick(1);
			{csw, wdis, fetch} = 3'b000;
			tick(1);
			chk("pc_step", pc, 16'h0001);
			chk("clk_hf", 16'(csel), 16'(CLK_HF));
			chk("wdt_off", 16'(wen), 16'h0000);
			src[i] = 1'b1;
			wait_halt(1'b1, 8);
			chk("cause", 16'(cause), 16'(8'h01 << cbit[i]));
			chk("periph", 16'(prst), 16'h0001);
			chk("por_only", 16'(porr), 16'h0000);
			chk("irq_off", 16'(irqd), 16'h0001);
			chk("tmr_off", 16'(tmd), 16'h0001);
			chk("oe_n_src", 16'(pin_oe_n), 16'(i != 2));
			ports(8'hff, 8'hff, 8'hff);
			tick(3);
			src[i] = 1'b0;
			wait_halt(1'b0, RST + 10);
			win("release", RST, RST + 4);
			run_dflt();
		end
		ram_chk();
		// Clock enable low freezes the program counter
		ce = 1'b0;
		fetch = 1'b1;
		tick(3);
		chk("pc_frozen", pc, 16'h0000);
		ce = 1'b1;
		tick(1);
		fetch = 1'b0;
		chk("pc_thawed", pc, 16'h0001);
		// Retention through a software reset
		rdat = 1'b1;
		rwr = 1'b1;
		tick(1);
		rwr = 1'b0;
		cfg_ports();
		src[1] = 1'b1;
		wait_halt(1'b1, 8);
		ports(pl, po, pp);
		chk("conv_keep", 16'(cret), 16'h0001);
		chk("vref_keep", 16'(vret), 16'h0001);
		src[1] = 1'b0;
		wait_halt(1'b0, RST + 10);
		// Short pin pulse ignored, long one resets
		pin.pull_low(100);
		tick(4);
		chk("short_pin", 16'(halt), 16'h0000);
		pin.pull_low(160);
		wait_halt(1'b1, 8);
		chk("cause_pin", 16'(cause), 16'h0002);
		chk("oe_n_pin", 16'(pin_oe_n), 16'h0001);
		wait_halt(1'b0, RST + 10);
		// Clock stops
		edge_on = 1'b0;
		wait_halt(1'b1, MCD + 10);
		win("mcd_time", MCD - 5, MCD + 4);
		chk("cause_mcd", 16'(cause), 16'h0040);
		edge_on = 1'b1;
		wait_halt(1'b0, RST + 20);
		// Idle and wake-up
		idle = 1'b1;
		tick(1);
		idle = 1'b0;
		tick(2);
		chk("idle", 16'(halt), 16'h0001);
		wake = 1'b1;
		tick(1);
		wake = 1'b0;
		wait_halt(1'b0, 4);
		n++;
		win("wake", 2, 3);
		// Power-on clears retention, memory survives
		por();
		ram_chk();
		complete_run();
	end

	initial begin
		#2000000;
		error_cnt++;
		complete_run();
	end
endmodule
